// ===== verilog/clock_gen_regs.vh
// Register map, field positions and reset values of the clock generator control bank.
// Assumes inclusion by the design files and the test bench of this bank.
`ifndef CLOCK_GEN_REGS_VH
`define CLOCK_GEN_REGS_VH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define REG_CPU_DIV 8'h05
`define REG_PANEL_DIV 8'h09
`define REG_REV_VENDOR 8'h0B
`define REG_PART 8'h0C
`define REG_SPARE_A 8'h0D
`define REG_SPARE_B 8'h0E
`define REG_READ_LEN 8'h0F
`define REG_RSVD_FIRST 8'h10
`define REG_RSVD_LAST 8'h28
`define REG_PROG_EN 8'h29

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define READ_LEN_MSB 5
`define READ_LEN_RESET 6'h0F
`define PROG_EN_RESET 2'h0
`define CPU_GATE_BIT 1
`define PANEL_GATE_BIT 0
// Identity codes: arbitrary values
`define REV_CODE 4'h1
`define VENDOR_CODE 4'h5
`define PART_CODE 4'hA
`define RSVD_NIBBLE 4'h0
`define RSVD_PAIR 2'h0
`define ZERO_BYTE 8'h00
`define RELEASE_BYTE 8'hFF

// ----------------------------------------
// Divider presets
// ----------------------------------------
`define FS_CPU_TOP 2'h3
`define CPU_DIV_TOP 8'h7D
`define CPU_DIV_OTHER 8'h60
`define PANEL_DIV_RESET 8'h00

// ----------------------------------------
// Serial bus
// ----------------------------------------
`define SMB_ADDR 7'h69
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0

`endif

// ===== verilog/smb_line_sampler.v
// Samples the two serial bus lines and flags start, stop and clock edges.
// Assumes both lines synchronous to clk_in and idle high.
`include "clock_gen_regs.vh"

module smb_line_sampler (
	// Clock and control
	input wire clk_in,
	input wire rst_n_in,
	input wire ce_in,
	// Bus lines
	input wire scl_in,
	input wire sda_in,
	// Events
	output wire start_out,
	output wire stop_out,
	output wire scl_rise_out,
	output wire scl_fall_out,
	output wire sda_bit_out
);

	reg scl_now;
	reg sda_now;
	reg scl_prev;
	reg sda_prev;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			scl_now <= 1'b1;
			sda_now <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else if (ce_in) begin
			scl_now <= scl_in;
			sda_now <= sda_in;
			scl_prev <= scl_now;
			sda_prev <= sda_now;
		end
	end

	assign start_out = scl_now & scl_prev & sda_prev & ~sda_now;
	assign stop_out = scl_now & scl_prev & ~sda_prev & sda_now;
	assign scl_rise_out = scl_now & ~scl_prev;
	assign scl_fall_out = ~scl_now & scl_prev;
	assign sda_bit_out = sda_now;

endmodule

// ===== verilog/test_mode_latch.v
// Power-up capture of the test select pin and live output mode control.
// Assumes rst_n_in is the power-on reset of the part.
`include "clock_gen_regs.vh"

module test_mode_latch (
	// Clock and control
	input wire clk_in,
	input wire rst_n_in,
	input wire ce_in,
	// Test pins
	input wire test_sel_in,
	input wire test_choice_in,
	// Output mode
	output reg test_mode_out,
	output reg clk_outputs_on_out,
	output reg ref_div_select_out
);

	reg captured;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			captured <= 1'b0;
			test_mode_out <= 1'b0;
			clk_outputs_on_out <= 1'b1;
			ref_div_select_out <= 1'b0;
		end else if (ce_in) begin
			// First enabled edge after power-up only
			if (!captured) begin
				captured <= 1'b1;
				test_mode_out <= test_sel_in; // R7
			end
			// Mode sticky until power cycle; in test mode outputs follow the test choice pin on every enabled edge
			clk_outputs_on_out <= ~test_mode_out | test_choice_in; // R8 R9
			ref_div_select_out <= test_mode_out & test_choice_in; // R9
		end
	end

endmodule

// ===== verilog/clock_gen_ctrl.v
// Control register bank of the clock generator, reached over the serial bus pins.
// Assumes a bus master doing block writes and block reads; lines synchronous to clk_in.
`include "clock_gen_regs.vh"

// Function
// R1 - Read-only byte: revision high, vendor low nibble
// R2 - Read-only part code in bits 7:4
// R3 - Six-bit byte count sets block read length
// R4 - CPU divider written only when its gate set
// R5 - Panel divider written only when its gate set
// R6 - Bytes 16 to 40 have no function
// R7 - Test select pin sampled at power-up
// R8 - Test mode left only by power cycle
// R9 - Test choice pin: high-Z or divided reference
// R10 - CPU divider preset from latched frequency select
// R11 - Reserved bits and bytes ignore writes, read default
module clock_gen_ctrl (
	// Clock and control
	input wire clk_in,
	input wire rst_n_in,
	input wire ce_in,
	// Serial bus
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n_out,
	// Straps and test pins
	input wire [1:0] freq_sel_in,
	input wire test_sel_in,
	input wire test_choice_in,
	// Clock output control
	output wire test_mode_out,
	output wire clk_outputs_on_out,
	output wire ref_div_select_out,
	output reg [7:0] cpu_divider_out,
	output reg [7:0] panel_divider_out
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_CMD = 3'h2;
	localparam ST_WCNT = 3'h3;
	localparam ST_WDATA = 3'h4;
	localparam ST_ACK = 3'h5;
	localparam ST_TX = 3'h6;
	localparam ST_TXACK = 3'h7;

	wire start_p;
	wire stop_p;
	wire rise_p;
	wire fall_p;
	wire sda_bit;

	reg [2:0] state;
	reg [2:0] after_ack;
	reg [2:0] bit_cnt;
	reg [7:0] shreg;
	reg [7:0] tx_byte;
	reg got_byte;
	reg first_tx;
	reg host_acked;
	reg [7:0] ptr;
	reg [7:0] wr_left;
	reg [5:0] rd_left;
	reg [5:0] read_length;
	reg [1:0] prog_enable;
	reg preset_done;
	reg [7:0] next_tx;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	smb_line_sampler u_lines (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.start_out(start_p),
		.stop_out(stop_p),
		.scl_rise_out(rise_p),
		.scl_fall_out(fall_p),
		.sda_bit_out(sda_bit)
	);

	test_mode_latch u_test (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.test_sel_in(test_sel_in),
		.test_choice_in(test_choice_in),
		.test_mode_out(test_mode_out),
		.clk_outputs_on_out(clk_outputs_on_out),
		.ref_div_select_out(ref_div_select_out)
	);

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	function [7:0] read_reg;
		input [7:0] addr;
		begin
			case (addr)
				`REG_REV_VENDOR: read_reg = {`REV_CODE, `VENDOR_CODE}; // R1
				`REG_PART: read_reg = {`PART_CODE, `RSVD_NIBBLE}; // R2
				`REG_READ_LEN: read_reg = {`RSVD_PAIR, read_length}; // R3 R11
				`REG_PROG_EN: read_reg = {6'h00, prog_enable}; // R11
				`REG_CPU_DIV: read_reg = cpu_divider_out;
				`REG_PANEL_DIV: read_reg = panel_divider_out;
				default: read_reg = `ZERO_BYTE; // R6 R11
			endcase
		end
	endfunction

	// Offset of the following byte; wraps from 8'hFF to 8'h00
	function [7:0] next_ptr;
		input [7:0] addr;
		begin
			next_ptr = addr + 8'h01;
		end
	endfunction

	// Bytes still owed to the host in a block read
	function [5:0] next_left;
		input [5:0] left;
		begin
			next_left = left - 6'h01;
		end
	endfunction

	// Byte to send next: count first, then data, then released line
	always @* begin
		if (first_tx) begin
			next_tx = {`RSVD_PAIR, read_length}; // R3
		end else if (rd_left != 6'h00) begin
			next_tx = read_reg(ptr);
		end else begin
			next_tx = `RELEASE_BYTE; // R3
		end
	end

	// ----------------------------------------
	// Bus protocol and register writes
	// ----------------------------------------
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			after_ack <= ST_IDLE;
			bit_cnt <= `BIT_FIRST;
			shreg <= `ZERO_BYTE;
			tx_byte <= `RELEASE_BYTE;
			got_byte <= 1'b0;
			first_tx <= 1'b1;
			host_acked <= 1'b0;
			ptr <= `ZERO_BYTE;
			wr_left <= `ZERO_BYTE;
			rd_left <= 6'h00;
			read_length <= `READ_LEN_RESET; // R3
			prog_enable <= `PROG_EN_RESET; // R4 R5
			preset_done <= 1'b0;
			cpu_divider_out <= `CPU_DIV_OTHER;
			panel_divider_out <= `PANEL_DIV_RESET;
			sda_out <= 1'b0;
			sda_oe_n_out <= 1'b1;
		end else if (ce_in) begin
			if (stop_p) begin
				state <= ST_IDLE;
				sda_oe_n_out <= 1'b1;
			end else if (start_p) begin
				state <= ST_ADDR;
				bit_cnt <= `BIT_FIRST;
				got_byte <= 1'b0;
				first_tx <= 1'b1;
				sda_oe_n_out <= 1'b1;
			end else begin
				case (state)
					ST_ADDR, ST_CMD, ST_WCNT, ST_WDATA: begin
						if (rise_p && !got_byte) begin
							shreg <= {shreg[6:0], sda_bit};
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == `BIT_LAST) begin
								got_byte <= 1'b1;
							end
						end else if (fall_p && got_byte) begin
							got_byte <= 1'b0;
							sda_oe_n_out <= 1'b0;
							state <= ST_ACK;
							case (state)
								ST_ADDR: begin
									if (shreg[7:1] == `SMB_ADDR) begin
										after_ack <= shreg[0] ? ST_TX : ST_CMD;
									end else begin
										sda_oe_n_out <= 1'b1;
										state <= ST_IDLE;
									end
								end
								ST_CMD: begin
									ptr <= shreg;
									after_ack <= ST_WCNT;
								end
								ST_WCNT: begin
									wr_left <= shreg;
									after_ack <= ST_WDATA;
								end
								default: begin
									after_ack <= ST_WDATA;
									if (wr_left != `ZERO_BYTE) begin
										wr_left <= wr_left - 8'h01;
										ptr <= next_ptr(ptr);
										case (ptr)
											`REG_READ_LEN: begin
												read_length <= shreg[`READ_LEN_MSB:0]; // R3 R11
											end
											`REG_PROG_EN: begin
												prog_enable <= shreg[`CPU_GATE_BIT:`PANEL_GATE_BIT]; // R11
											end
											`REG_CPU_DIV: begin
												if (prog_enable[`CPU_GATE_BIT]) begin
													cpu_divider_out <= shreg; // R4
												end
											end
											`REG_PANEL_DIV: begin
												if (prog_enable[`PANEL_GATE_BIT]) begin
													panel_divider_out <= shreg; // R5
												end
											end
											default: begin
												ptr <= next_ptr(ptr); // R6 R11
											end
										endcase
									end
								end
							endcase
						end
					end
					ST_ACK: begin
						if (fall_p) begin
							bit_cnt <= `BIT_FIRST;
							if (after_ack == ST_TX) begin
								tx_byte <= {next_tx[6:0], 1'b1};
								sda_oe_n_out <= next_tx[7];
								if (first_tx) begin
									first_tx <= 1'b0;
									rd_left <= read_length; // R3
								end else if (rd_left != 6'h00) begin
									rd_left <= next_left(rd_left);
									ptr <= next_ptr(ptr);
								end
								state <= ST_TX;
							end else begin
								sda_oe_n_out <= 1'b1;
								state <= after_ack;
							end
						end
					end
					ST_TX: begin
						if (fall_p) begin
							if (bit_cnt == `BIT_LAST) begin
								sda_oe_n_out <= 1'b1;
								state <= ST_TXACK;
							end else begin
								sda_oe_n_out <= tx_byte[7];
								tx_byte <= {tx_byte[6:0], 1'b1};
								bit_cnt <= bit_cnt + 3'h1;
							end
						end
					end
					ST_TXACK: begin
						if (rise_p) begin
							host_acked <= ~sda_bit;
						end else if (fall_p) begin
							if (host_acked) begin
								after_ack <= ST_TX;
								bit_cnt <= `BIT_FIRST;
								tx_byte <= {next_tx[6:0], 1'b1};
								sda_oe_n_out <= next_tx[7];
								if (first_tx) begin
									first_tx <= 1'b0;
									rd_left <= read_length;
								end else if (rd_left != 6'h00) begin
									rd_left <= next_left(rd_left);
									ptr <= next_ptr(ptr);
								end
								state <= ST_TX;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					default: begin
						sda_oe_n_out <= 1'b1;
					end
				endcase
			end
			// Divider preset from frequency strap, once after power-up
			if (!preset_done) begin
				preset_done <= 1'b1;
				if (freq_sel_in == `FS_CPU_TOP) begin
					cpu_divider_out <= `CPU_DIV_TOP; // R10
				end else begin
					cpu_divider_out <= `CPU_DIV_OTHER; // R10
				end
			end
		end
	end

endmodule

// ===== tb/clock_gen_ctrl_asserts.sv
// Concurrent checks on the ports of the control bank.
// Assumes binding to clock_gen_ctrl; a single clock domain.
module clock_gen_ctrl_asserts (
	// Clock and control
	input wire clk_in,
	input wire rst_n_in,
	input wire ce_in,
	// Pins
	input wire scl_in,
	input wire [1:0] freq_sel_in,
	input wire test_sel_in,
	input wire test_choice_in,
	// Outputs watched
	input wire test_mode_out,
	input wire clk_outputs_on_out,
	input wire ref_div_select_out,
	input wire [7:0] cpu_divider_out,
	input wire [7:0] panel_divider_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	reset_values_a: assert property (disable iff (1'b0) !rst_n_in |=> !test_mode_out &&
		cpu_divider_out == 8'h60 && panel_divider_out == 8'h00) else $error("bad reset value");
	mode_capture_a: assert property ($rose(rst_n_in) && ce_in |=>
		test_mode_out == $past(test_sel_in)) else $error("test select not captured");
	preset_a: assert property ($rose(rst_n_in) && ce_in |=> cpu_divider_out ==
		($past(freq_sel_in) == 2'h3 ? 8'h7D : 8'h60)) else $error("cpu preset wrong");
	mode_fixed_a: assert property (!$rose(rst_n_in) |=> $stable(test_mode_out))
		else $error("test mode changed");
	test_follow_a: assert property (test_mode_out && ce_in |=>
		clk_outputs_on_out == $past(test_choice_in) && ref_div_select_out == $past(test_choice_in))
		else $error("test outputs wrong");
	normal_out_a: assert property (!test_mode_out |=> clk_outputs_on_out && !ref_div_select_out)
		else $error("normal outputs wrong");
	cpu_change_a: assert property ($changed(cpu_divider_out) && $past(rst_n_in, 2) |-> !scl_in)
		else $error("cpu divider changed off a write");
	panel_change_a: assert property ($changed(panel_divider_out) && $past(rst_n_in, 2) |-> !scl_in)
		else $error("panel divider changed off a write");
	outputs_frozen_a: assert property (!ce_in |=> $stable(clk_outputs_on_out) &&
		$stable(ref_div_select_out)) else $error("outputs moved with enable low");
endmodule

bind clock_gen_ctrl clock_gen_ctrl_asserts chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.ce_in(ce_in), .scl_in(scl_in), .freq_sel_in(freq_sel_in), .test_sel_in(test_sel_in),
	.test_choice_in(test_choice_in), .test_mode_out(test_mode_out),
	.clk_outputs_on_out(clk_outputs_on_out), .ref_div_select_out(ref_div_select_out),
	.cpu_divider_out(cpu_divider_out), .panel_divider_out(panel_divider_out));

// ===== tb/smb_host.sv
// Serial bus host model: start, stop and byte transfers with acknowledge.
// Assumes the data line is resolved outside with a pull-up.
module smb_host (
	// Clock
	input wire clk_in,
	// Bus lines
	input wire sda_in,
	output reg scl_out,
	output reg sda_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// One third of a bit period, well above the sampler latency
	task automatic hp;
		repeat (8) @(posedge clk_in);
	endtask
	task automatic start;
		hp;
		sda_out <= 1'b1;
		hp;
		scl_out <= 1'b1;
		hp;
		sda_out <= 1'b0;
		hp;
		scl_out <= 1'b0;
	endtask
	task automatic stop;
		hp;
		sda_out <= 1'b0;
		hp;
		scl_out <= 1'b1;
		hp;
		sda_out <= 1'b1;
		hp;
	endtask
	task automatic bit_io(input logic b, output logic r);
		hp;
		sda_out <= b;
		hp;
		scl_out <= 1'b1;
		hp;
		r = sda_in;
		scl_out <= 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(last, r);
		ack = !r;
	endtask
endmodule

// ===== tb/clock_gen_id_count_test_regs_test.sv
// Self-checking bench for the clock generator control bank.
// Assumes the host model and the bound checker.
`include "clock_gen_regs.vh"
module clock_gen_id_count_test_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk_in = 1'b0;
	reg rst_n_in = 1'b0;
	reg ce_in = 1'b1;
	reg [1:0] freq_sel = 2'h3;
	reg test_sel = 1'b0;
	reg test_choice = 1'b0;
	wire scl, h_sda, dev_sda, dev_oe_n, t_mode, clk_on, ref_div;
	wire [7:0] cpu_div, pnl_div;
	wire sda = h_sda & (dev_oe_n | dev_sda);
	logic [7:0] got [0:7];
	logic ack;
	int n_fail = 0;
	int compares = 0;
	initial forever #50 clk_in = ~clk_in;
	clock_gen_ctrl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .scl_in(scl),
		.sda_in(sda), .sda_out(dev_sda), .sda_oe_n_out(dev_oe_n), .freq_sel_in(freq_sel),
		.test_sel_in(test_sel), .test_choice_in(test_choice), .test_mode_out(t_mode),
		.clk_outputs_on_out(clk_on), .ref_div_select_out(ref_div), .cpu_divider_out(cpu_div),
		.panel_divider_out(pnl_div));
	smb_host host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(h_sda));
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic power_up(input logic ts, input logic [1:0] fs);
		rst_n_in <= 1'b0;
		test_sel <= ts;
		freq_sel <= fs;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
	// Block write; byte i of d goes to offset off + i
	task automatic wr(input logic [7:0] off, input logic [39:0] d, input logic [7:0] n);
		logic [7:0] q;
		host.start;
		host.xfer({`SMB_ADDR, 1'b0}, 1'b1, q, ack);
		host.xfer(off, 1'b1, q, ack);
		host.xfer(n, 1'b1, q, ack);
		for (int i = 0; i < n; i++) host.xfer(d[8 * i +: 8], 1'b1, q, ack);
		host.stop;
	endtask
	// Block read of count byte plus n bytes, last one refused
	task automatic rd(input logic [7:0] off, input int n);
		host.start;
		host.xfer({`SMB_ADDR, 1'b0}, 1'b1, got[0], ack);
		host.xfer(off, 1'b1, got[0], ack);
		host.start;
		host.xfer({`SMB_ADDR, 1'b1}, 1'b1, got[0], ack);
		for (int i = 0; i <= n; i++) host.xfer(8'hFF, i == n, got[i], ack);
		host.stop;
	endtask
	initial begin
		repeat (90000) @(posedge clk_in);
		n_fail++;
		give_verdict;
	end
	initial begin
		@(posedge clk_in);
		power_up(1'b0, 2'h3);
		chk("cpu preset", cpu_div, `CPU_DIV_TOP);
		chk("normal mode", {5'h0, t_mode, clk_on, ref_div}, 8'h02);
		rd(8'h0B, 5);
		chk("count", got[0], 8'h0F);
		chk("rev vendor", got[1], {`REV_CODE, `VENDOR_CODE});
		chk("part", got[2], {`PART_CODE, `RSVD_NIBBLE});
		chk("spare a", got[3], 8'h00);
		chk("spare b", got[4], 8'h00);
		chk("length", got[5], 8'h0F);
		wr(8'h0B, 40'hC3_FF_FF_FF_FF, 5);
		rd(8'h0B, 4);
		chk("short count", got[0], 8'h03);
		chk("rev kept", got[1], {`REV_CODE, `VENDOR_CODE});
		chk("part kept", got[2], {`PART_CODE, `RSVD_NIBBLE});
		chk("spare kept", got[3], 8'h00);
		chk("past count", got[4], 8'hFF);
		wr(8'h05, 40'h33_00_00_00_7A, 5);
		chk("cpu gated", cpu_div, 8'h7D);
		chk("panel gated", pnl_div, 8'h00);
		wr(8'h29, 40'h02, 1);
		wr(8'h05, 40'h33_00_00_00_7A, 5);
		chk("cpu open", cpu_div, 8'h7A);
		chk("panel shut", pnl_div, 8'h00);
		wr(8'h29, 40'h01, 1);
		wr(8'h05, 40'h33_00_00_00_11, 5);
		chk("cpu shut", cpu_div, 8'h7A);
		chk("panel open", pnl_div, 8'h33);
		wr(8'h28, 40'hFF_AA, 2);
		rd(8'h28, 2);
		chk("reserved byte", got[1], 8'h00);
		chk("gate byte", got[2], 8'h03);
		power_up(1'b1, 2'h0);
		chk("test entry", {7'h0, t_mode}, 8'h01);
		chk("cpu other", cpu_div, `CPU_DIV_OTHER);
		chk("outputs off", {6'h0, clk_on, ref_div}, 8'h00);
		test_choice <= 1'b1;
		test_sel <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk("ref out", {6'h0, clk_on, ref_div}, 8'h03);
		ce_in <= 1'b0;
		test_choice <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk("frozen outputs", {6'h0, clk_on, ref_div}, 8'h03);
		ce_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("outputs off again", {6'h0, clk_on, ref_div}, 8'h00);
		wr(8'h29, 40'h03, 1);
		chk("test sticky", {7'h0, t_mode}, 8'h01);
		power_up(1'b0, 2'h3);
		chk("normal again", {5'h0, t_mode, clk_on, ref_div}, 8'h02);
		give_verdict;
	end
endmodule
